//--- rtl/kpm_mem.sv
`timescale 1ns/1ns
// small point-value memory, registered read port
module kpm_mem (
  // clock
  input  wire logic                         mclk_i,
  // write port
  input  wire logic                         we_i,
  input  wire logic [kpm_pkg::PW-1:0]       waddr_i,
  input  wire logic [kpm_pkg::VW-1:0]       wdata_i,
  // read port
  input  wire logic [kpm_pkg::PW-1:0]       raddr_i,
  output logic      [kpm_pkg::VW-1:0]       rdata_o
);
  logic [kpm_pkg::VW-1:0] mem_q [kpm_pkg::NPTS];

  // values need no reset; mirror is refreshed by update reads
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : kpm_mem

//--- rtl/kpm_pkg.sv
package kpm_pkg;
  // table geometry
  localparam int NPTS       = 16;
  localparam int PW         = 4;
  localparam int GAW        = 16;
  localparam int VW         = 32;
  // per-point config word layout: ga | la | has_la | type | flags
  localparam int CFG_FLAGS  = 0;   // five behaviour flags
  localparam int F_READ     = 0;
  localparam int F_WRITE    = 1;
  localparam int F_XMIT     = 2;
  localparam int F_UPD      = 3;
  localparam int F_UPD2     = 4;
  localparam int CFG_ENC    = 5;   // 4-bit value_encoding_type
  localparam int CFG_HASLA  = 9;
  localparam int CFG_LA     = 10;
  localparam int CFG_GA     = 26;
  localparam int CFGW       = 42;
  // value_encoding_type codes
  localparam logic [3:0] ENC_SWITCH = 4'h0;
  localparam logic [3:0] ENC_DRIVE  = 4'h1;
  localparam logic [3:0] ENC_DIM    = 4'h2;
  localparam logic [3:0] ENC_SCALE  = 4'h3;
  localparam logic [3:0] ENC_CNT8   = 4'h4;
  localparam logic [3:0] ENC_CHAR   = 4'h5;
  localparam logic [3:0] ENC_FLT16  = 4'h6;
  localparam logic [3:0] ENC_CNT16  = 4'h7;
  localparam logic [3:0] ENC_FLT32  = 4'h8;
  localparam logic [3:0] ENC_CNT32  = 4'h9;
  // register offsets
  localparam logic [7:0] REG_CFG_LO = 8'h00; // ga,la low bits write staging
  localparam logic [7:0] REG_CFG_HI = 8'h04;
  localparam logic [7:0] REG_CFG_WR = 8'h08; // commit staging to point index
  localparam logic [7:0] REG_VAL_WR = 8'h0c; // host point write {idx, value in VAL_DATA}
  localparam logic [7:0] REG_VAL_DT = 8'h10;
  localparam logic [7:0] REG_VAL_RD = 8'h14; // select point to read
  localparam logic [7:0] REG_VAL_Q  = 8'h18; // value of selected point
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // telegram kinds to/from the bus
  localparam logic [1:0] TG_WRITE   = 2'h0;
  localparam logic [1:0] TG_READ    = 2'h1;
  localparam logic [1:0] TG_RESP    = 2'h2;
  // bus-loss debounce time
  localparam int CLK_MHZ    = 100;
  localparam int LOSS_US    = 10;
  localparam int LOSS_CYC   = LOSS_US * CLK_MHZ;
  typedef enum logic [1:0] {
    KPM_IDLE  = 2'b00,
    KPM_SCAN  = 2'b01,
    KPM_SEND  = 2'b10
  } kpm_state_t;
endpackage : kpm_pkg

//--- rtl/kpm_sync.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
// Contract
// - bus group write updates mirrored point value
// - per-point flag gates spontaneous host notify
// - host write sends telegram only if transmit
// - watch bus health, detect bus loss
// - on restore resend transmit points, issue updates
// - listening addresses act like main address
// - answer bus reads only with read flag
// - accept bus writes only with write flag
// - transmit point value change sends group write
// - startup/reset reads main group for update flag
// - alt-update reads first listening address
// - main group is send and target address
// - encoding, main group, five flags per point
// - support listed value encodings
module kpm_sync (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   sys_rst_i,
  // register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // bus receive: decoded telegrams
  input  wire logic                   rx_vld_i,
  input  wire logic [1:0]             rx_kind_i,
  input  wire logic [15:0]            rx_ga_i,
  input  wire logic [31:0]            rx_val_i,
  input  wire logic                   bus_ok_i,
  // bus transmit
  output logic                        tx_vld_o,
  output logic      [1:0]             tx_kind_o,
  output logic      [15:0]            tx_ga_o,
  output logic      [31:0]            tx_val_o,
  output logic      [3:0]             tx_enc_o,
  input  wire logic                   tx_rdy_i,
  // spontaneous host notification
  output logic                        ntf_vld_o,
  output logic      [3:0]             ntf_pt_o
);
  localparam int N = kpm_pkg::NPTS;
  localparam int LW = $clog2(kpm_pkg::LOSS_CYC + 1);

  // configuration and shadow values (needed for parallel lookup / replay)
  logic [kpm_pkg::CFGW-1:0] cfg_q [N];
  logic [N-1:0]             ntf_en_q;
  logic [31:0]              val_q [N];
  logic [31:0]              stg_lo_q, stg_hi_q, vdat_q;
  logic [3:0]               rsel_q;
  logic [31:0]              reg_rdata_q;

  // bus health
  logic [LW-1:0]            loss_cnt_q;
  logic                     bus_lost_q, bus_up_q, start_q;
  logic [7:0]               loss_evt_q;

  // replay and pending-send queues
  logic [N-1:0]             pend_wr_q, pend_rd_q, pend_rd2_q, pend_rsp_q;
  kpm_pkg::kpm_state_t      st_q;
  logic [3:0]               cur_q;
  logic                     tx_vld_q, ntf_vld_q;
  logic [1:0]               tx_kind_q;
  logic [15:0]              tx_ga_q;
  logic [31:0]              tx_val_q;
  logic [3:0]               tx_enc_q, ntf_pt_q;

  // flag extraction used at many places
  function automatic logic flag(input logic [kpm_pkg::CFGW-1:0] c, input int f);
    flag = c[kpm_pkg::CFG_FLAGS + f];
  endfunction : flag

  // mask value to the width of its encoding
  function automatic logic [31:0] enc_mask(input logic [3:0] e, input logic [31:0] v);
    unique case (e)
      kpm_pkg::ENC_SWITCH, kpm_pkg::ENC_DRIVE: enc_mask = {31'h0, v[0]};
      kpm_pkg::ENC_DIM:                        enc_mask = {28'h0, v[3:0]};
      kpm_pkg::ENC_SCALE, kpm_pkg::ENC_CNT8,
      kpm_pkg::ENC_CHAR:                       enc_mask = {24'h0, v[7:0]};
      kpm_pkg::ENC_FLT16, kpm_pkg::ENC_CNT16:  enc_mask = {16'h0, v[15:0]};
      default:                                 enc_mask = v;
    endcase
  endfunction : enc_mask

  // per-point address match against main and listening group
  logic [N-1:0] hit_main, hit_any, wr_ok, rd_ok, changed;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_match
      wire [15:0] ga = cfg_q[g][kpm_pkg::CFG_GA +: 16];
      wire [15:0] la = cfg_q[g][kpm_pkg::CFG_LA +: 16];
      wire        lv = cfg_q[g][kpm_pkg::CFG_HASLA];
      wire [3:0]  en = cfg_q[g][kpm_pkg::CFG_ENC +: 4];
      assign hit_main[g] = rx_vld_i && (rx_ga_i == ga);
      assign hit_any[g]  = hit_main[g] || (rx_vld_i && lv && rx_ga_i == la);
      // responses to update reads count as writes
      assign wr_ok[g]    = hit_any[g] && rx_kind_i != kpm_pkg::TG_READ
                           && flag(cfg_q[g], kpm_pkg::F_WRITE);
      assign rd_ok[g]    = hit_any[g] && rx_kind_i == kpm_pkg::TG_READ
                           && flag(cfg_q[g], kpm_pkg::F_READ);
      assign changed[g]  = wr_ok[g] && (enc_mask(en, rx_val_i) != val_q[g]);
    end
  endgenerate

  // host write decode
  wire       hw_cfg = reg_wr_i && reg_addr_i == kpm_pkg::REG_CFG_WR;
  wire       hw_val = reg_wr_i && reg_addr_i == kpm_pkg::REG_VAL_WR;
  wire [3:0] hidx   = reg_wdata_i[3:0];
  wire [3:0] henc   = cfg_q[hidx][kpm_pkg::CFG_ENC +: 4];
  wire [31:0] hval  = enc_mask(henc, vdat_q);
  wire       hxmit  = flag(cfg_q[hidx], kpm_pkg::F_XMIT);

  // bus loss detection: bus must be absent for a debounce time
  wire loss_done = loss_cnt_q == LW'(kpm_pkg::LOSS_CYC);
  wire restore   = (bus_lost_q || start_q) && bus_ok_i;

  // lowest pending point for the sender
  logic [N-1:0] any_pend;
  assign any_pend = pend_rsp_q | pend_wr_q | pend_rd_q | pend_rd2_q;
  logic [3:0] nxt;
  always_comb begin
    nxt = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (any_pend[i]) begin
        nxt = 4'(i);
      end
    end
  end
  wire [kpm_pkg::CFGW-1:0] ncfg = cfg_q[nxt];
  wire send_go = st_q == kpm_pkg::KPM_IDLE && |any_pend;

  // config store and value mirror
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < N; i++) begin
      if (sys_rst_i) begin
        cfg_q[i] <= '0;
        val_q[i] <= '0;
      end else if (hw_cfg && hidx == 4'(i)) begin
        cfg_q[i] <= {stg_hi_q[9:0], stg_lo_q};
      end else if (hw_val && hidx == 4'(i)) begin
        val_q[i] <= hval;
      end else if (wr_ok[i]) begin
        val_q[i] <= enc_mask(cfg_q[i][kpm_pkg::CFG_ENC +: 4], rx_val_i);
      end
    end
  end

  // host registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stg_lo_q <= '0;
      stg_hi_q <= '0;
      vdat_q   <= '0;
      rsel_q   <= '0;
      ntf_en_q <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == kpm_pkg::REG_CFG_LO) stg_lo_q <= reg_wdata_i;
      if (reg_addr_i == kpm_pkg::REG_CFG_HI) stg_hi_q <= reg_wdata_i;
      if (reg_addr_i == kpm_pkg::REG_VAL_DT) vdat_q <= reg_wdata_i;
      if (reg_addr_i == kpm_pkg::REG_VAL_RD) rsel_q <= reg_wdata_i[3:0];
      if (hw_cfg) ntf_en_q[hidx] <= reg_wdata_i[8];
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  wire [31:0] status = {16'h0, loss_evt_q, 5'h0, start_q, bus_lost_q, bus_up_q};
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_q <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        kpm_pkg::REG_VAL_Q:  reg_rdata_q <= val_q[rsel_q];
        kpm_pkg::REG_STATUS: reg_rdata_q <= status;
        kpm_pkg::REG_CFG_LO: reg_rdata_q <= stg_lo_q;
        kpm_pkg::REG_CFG_HI: reg_rdata_q <= stg_hi_q;
        default:             reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // bus health monitor
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      loss_cnt_q <= '0;
      bus_lost_q <= 1'b0;
      bus_up_q   <= 1'b0;
      start_q    <= 1'b1;
      loss_evt_q <= '0;
    end else begin
      bus_up_q <= bus_ok_i;
      if (bus_ok_i) begin
        loss_cnt_q <= '0;
      end else if (!loss_done) begin
        loss_cnt_q <= loss_cnt_q + LW'(1);
      end
      if (restore) begin
        bus_lost_q <= 1'b0;
        start_q    <= 1'b0;
      end else if (loss_done && !bus_lost_q) begin
        bus_lost_q <= 1'b1;
        loss_evt_q <= loss_evt_q + 8'h1;
      end
    end
  end

  // pending work per point; new requests win over the sender's clear
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < N; i++) begin
      if (sys_rst_i) begin
        pend_wr_q[i]  <= 1'b0;
        pend_rd_q[i]  <= 1'b0;
        pend_rd2_q[i] <= 1'b0;
        pend_rsp_q[i] <= 1'b0;
      end else begin
        if (send_go && nxt == 4'(i)) begin
          if (pend_rsp_q[i]) pend_rsp_q[i] <= 1'b0;
          else if (pend_wr_q[i]) pend_wr_q[i] <= 1'b0;
          else if (pend_rd_q[i]) pend_rd_q[i] <= 1'b0;
          else pend_rd2_q[i] <= 1'b0;
        end
        if (rd_ok[i]) pend_rsp_q[i] <= 1'b1;
        if (hw_val && hidx == 4'(i) && hxmit) pend_wr_q[i] <= 1'b1;
        if (restore && flag(cfg_q[i], kpm_pkg::F_XMIT) && !start_q)
          pend_wr_q[i] <= 1'b1;
        if (restore && flag(cfg_q[i], kpm_pkg::F_UPD)) pend_rd_q[i] <= 1'b1;
        if (restore && flag(cfg_q[i], kpm_pkg::F_UPD2) && cfg_q[i][kpm_pkg::CFG_HASLA])
          pend_rd2_q[i] <= 1'b1;
      end
    end
  end

  // sender: one telegram at a time, held until taken
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_q      <= kpm_pkg::KPM_IDLE;
      cur_q     <= '0;
      tx_vld_q  <= 1'b0;
      tx_kind_q <= kpm_pkg::TG_WRITE;
      tx_ga_q   <= '0;
      tx_val_q  <= '0;
      tx_enc_q  <= '0;
    end else begin
      unique case (st_q)
        kpm_pkg::KPM_IDLE: begin
          if (send_go) begin
            cur_q    <= nxt;
            tx_vld_q <= 1'b1;
            // recut: a stored value may predate a change of encoding
            tx_val_q <= enc_mask(ncfg[kpm_pkg::CFG_ENC +: 4], val_q[nxt]);
            tx_enc_q <= ncfg[kpm_pkg::CFG_ENC +: 4];
            tx_ga_q  <= ncfg[kpm_pkg::CFG_GA +: 16];
            if (pend_rsp_q[nxt]) tx_kind_q <= kpm_pkg::TG_RESP;
            else if (pend_wr_q[nxt]) tx_kind_q <= kpm_pkg::TG_WRITE;
            else begin
              tx_kind_q <= kpm_pkg::TG_READ;
              if (!pend_rd_q[nxt]) tx_ga_q <= ncfg[kpm_pkg::CFG_LA +: 16];
            end
            st_q <= kpm_pkg::KPM_SEND;
          end
        end
        kpm_pkg::KPM_SEND: begin
          if (tx_rdy_i) begin
            tx_vld_q <= 1'b0;
            st_q     <= kpm_pkg::KPM_IDLE;
          end
        end
        default: st_q <= kpm_pkg::KPM_IDLE;
      endcase
    end
  end

  // spontaneous notify of bus-originated changes, lowest point wins
  logic [3:0] chg_pt;
  always_comb begin
    chg_pt = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (changed[i] && ntf_en_q[i]) chg_pt = 4'(i);
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ntf_vld_q <= 1'b0;
      ntf_pt_q  <= '0;
    end else begin
      ntf_vld_q <= |(changed & ntf_en_q);
      ntf_pt_q  <= chg_pt;
    end
  end

  // value memory takes every accepted bus value at the notify index chg_pt; its read data are left unconnected, host reads use val_q
  kpm_mem u_mem (
    .mclk_i  (mclk_i),
    .we_i    (|wr_ok),
    .waddr_i (chg_pt),
    .wdata_i (rx_val_i),
    .raddr_i (cur_q),
    .rdata_o ()
  );

  assign reg_rdata_o = reg_rdata_q;
  assign tx_vld_o    = tx_vld_q;
  assign tx_kind_o   = tx_kind_q;
  assign tx_ga_o     = tx_ga_q;
  assign tx_val_o    = tx_val_q;
  assign tx_enc_o    = tx_enc_q;
  assign ntf_vld_o   = ntf_vld_q;
  assign ntf_pt_o    = ntf_pt_q;
endmodule : kpm_sync

//--- sim/knx_point_mirror_sync_test.sv
`timescale 1ns/1ns
// bench: register port tasks, bus model, expected telegrams
module knx_point_mirror_sync_test;
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        bus_ok_i = 1'b0, slow = 1'b0, rx_vld_i, tx_vld_o, tx_rdy_i, ntf_vld_o;
  logic [7:0]  reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rx_val_i, tx_val_o;
  logic [1:0]  rx_kind_i, tx_kind_o;
  logic [15:0] rx_ga_i, tx_ga_o;
  logic [3:0]  tx_enc_o, ntf_pt_o, last_pt = 4'h0;
  int          err_total = 0, n_compared = 0, ntf_n = 0, cyc = 0;
  kpm_sync i_kpm_sync (.*);
  kpm_bus_model i_kpm_bus_model (.mclk_i(mclk_i), .slow_i(slow), .g_vld_i(tx_vld_o),
    .g_kind_i(tx_kind_o), .g_ga_i(tx_ga_o), .g_val_i(tx_val_o), .g_enc_i(tx_enc_o),
    .rdy_o(tx_rdy_i), .r_vld_o(rx_vld_i), .r_kind_o(rx_kind_i), .r_ga_o(rx_ga_i),
    .r_val_o(rx_val_i));
  always #5 mclk_i = ~mclk_i;
  // notify tally and hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (ntf_vld_o === 1'b1) ntf_n <= ntf_n + 1;
    if (ntf_vld_o === 1'b1) last_pt <= ntf_pt_o;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    // data stand for the whole cycle after the strobe; take them at its closing edge
    @(posedge mclk_i);
    chk(64'(reg_rdata_o & m), 64'(e));
  endtask : rd
  // point setup: flags, encoding, listening and main group, notify
  task automatic cfg(input logic [3:0] i, input logic [4:0] f, input logic [3:0] e,
                     input logic [15:0] la, input logic [15:0] ga, input logic n);
    logic [41:0] w;
    w = {ga, la, la != 16'h0, e, f};
    wr(kpm_pkg::REG_CFG_LO, w[31:0]);
    wr(kpm_pkg::REG_CFG_HI, {22'h0, w[41:32]});
    wr(kpm_pkg::REG_CFG_WR, {23'h0, n, 4'h0, i});
  endtask : cfg
  // next accepted telegram; a read carries no value to compare
  task automatic exp_tx(input logic [1:0] k, input logic [15:0] ga, input logic [35:0] ev);
    logic [53:0] g;
    int          n;
    n = 0;
    while (i_kpm_bus_model.log_q.size() == 0 && n < 300) begin
      @(posedge mclk_i);
      n++;
    end
    g = (n < 300) ? i_kpm_bus_model.log_q.pop_front() : 54'h0;
    chk(64'(g[49:32]), 64'({k, ga}));
    if (k != kpm_pkg::TG_READ) chk(64'({g[53:50], g[31:0]}), 64'(ev));
  endtask : exp_tx
  task automatic quiet(input int n, input logic [3:0] p);
    repeat (20) @(posedge mclk_i);
    chk(64'(i_kpm_bus_model.log_q.size()), 64'h0);
    chk({28'h0, ntf_n, last_pt}, {28'h0, n, p});
  endtask : quiet
  task automatic pval(input logic [3:0] i, input logic [31:0] e);
    wr(kpm_pkg::REG_VAL_RD, {28'h0, i});
    rd(kpm_pkg::REG_VAL_Q, 32'hffffffff, e);
  endtask : pval
  function automatic logic [31:0] wmask(input logic [3:0] e);
    return e < 4'h2 ? 32'h1 : e == 4'h2 ? 32'hf : e < 4'h6 ? 32'hff : e < 4'h8 ? 32'hffff : '1;
  endfunction : wmask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // startup with bus down during setup, then bus up: update reads only
    cfg(4'h0, 5'h0a, kpm_pkg::ENC_FLT16, 16'h0, 16'h0901, 1'b0);
    cfg(4'h1, 5'h12, kpm_pkg::ENC_CNT8, 16'h0a02, 16'h0902, 1'b1);
    cfg(4'h2, 5'h07, kpm_pkg::ENC_CNT16, 16'h0b03, 16'h0903, 1'b1);
    cfg(4'h3, 5'h01, kpm_pkg::ENC_SCALE, 16'h0, 16'h0904, 1'b1);
    bus_ok_i <= 1'b1;
    exp_tx(kpm_pkg::TG_READ, 16'h0901, 36'h0);
    exp_tx(kpm_pkg::TG_READ, 16'h0a02, 36'h0);
    quiet(0, 4'h0);
    i_kpm_bus_model.send(kpm_pkg::TG_RESP, 16'h0a02, 32'h12345678);
    pval(4'h1, 32'h78);
    i_kpm_bus_model.send(kpm_pkg::TG_RESP, 16'h0901, 32'h87654321);
    pval(4'h0, 32'h4321);
    quiet(1, 4'h1);
    $display("test startup done");
    // bus writes: listening address, refused write
    i_kpm_bus_model.send(kpm_pkg::TG_WRITE, 16'h0b03, 32'habcd1234);
    pval(4'h2, 32'h1234);
    i_kpm_bus_model.send(kpm_pkg::TG_WRITE, 16'h0904, 32'h55);
    pval(4'h3, 32'h0);
    quiet(2, 4'h2);
    $display("test bus write done");
    // bus reads: refused on a point without the read flag
    i_kpm_bus_model.send(kpm_pkg::TG_READ, 16'h0901, 32'h0);
    i_kpm_bus_model.send(kpm_pkg::TG_READ, 16'h0903, 32'h0);
    i_kpm_bus_model.send(kpm_pkg::TG_READ, 16'h0904, 32'h0);
    exp_tx(kpm_pkg::TG_RESP, 16'h0903, {kpm_pkg::ENC_CNT16, 32'h1234});
    exp_tx(kpm_pkg::TG_RESP, 16'h0904, {kpm_pkg::ENC_SCALE, 32'h0});
    quiet(2, 4'h2);
    $display("test bus read done");
    // host writes under a stalling bus
    slow <= 1'b1;
    wr(kpm_pkg::REG_VAL_DT, 32'hffff0055);
    wr(kpm_pkg::REG_VAL_WR, 32'h2);
    exp_tx(kpm_pkg::TG_WRITE, 16'h0903, {kpm_pkg::ENC_CNT16, 32'h55});
    wr(kpm_pkg::REG_VAL_WR, 32'h0);
    pval(4'h0, 32'h55);
    quiet(2, 4'h2);
    slow <= 1'b0;
    $display("test host write done");
    // bus loss and return: resend transmit points, reread update points
    bus_ok_i <= 1'b0;
    repeat (kpm_pkg::LOSS_CYC + 100) @(posedge mclk_i);
    rd(kpm_pkg::REG_STATUS, 32'hff03, 32'h0102);
    bus_ok_i <= 1'b1;
    exp_tx(kpm_pkg::TG_READ, 16'h0901, 36'h0);
    exp_tx(kpm_pkg::TG_READ, 16'h0a02, 36'h0);
    exp_tx(kpm_pkg::TG_WRITE, 16'h0903, {kpm_pkg::ENC_CNT16, 32'h55});
    quiet(2, 4'h2);
    $display("test bus loss done");
    // every encoding code, widest value from the host
    for (int e = 0; e < 10; e++) begin
      cfg(4'h4, 5'h04, e[3:0], 16'h0, 16'h0905, 1'b0);
      wr(kpm_pkg::REG_VAL_DT, 32'hffffffff);
      wr(kpm_pkg::REG_VAL_WR, 32'h4);
      exp_tx(kpm_pkg::TG_WRITE, 16'h0905, {e[3:0], wmask(e[3:0])});
    end
    // staging read-back of the last point setup, then an unmapped offset
    rd(kpm_pkg::REG_CFG_LO, 32'hffffffff, 32'h14000124);
    rd(kpm_pkg::REG_CFG_HI, 32'hffffffff, 32'h00000024);
    rd(8'h20, 32'hffffffff, 32'h00000000);
    $display("test encodings done");
    final_report();
  end
endmodule : knx_point_mirror_sync_test

//--- sim/kpm_bus_model.sv
`timescale 1ns/1ns
// bus-side model: accepts telegrams, may stall, injects decoded ones
module kpm_bus_model (
  // clock and pacing
  input  wire logic        mclk_i,
  input  wire logic        slow_i,
  // telegrams from the gateway
  input  wire logic        g_vld_i,
  input  wire logic [1:0]  g_kind_i,
  input  wire logic [15:0] g_ga_i,
  input  wire logic [31:0] g_val_i,
  input  wire logic [3:0]  g_enc_i,
  output logic             rdy_o,
  // telegrams to the gateway
  output logic             r_vld_o,
  output logic [1:0]       r_kind_o,
  output logic [15:0]      r_ga_o,
  output logic [31:0]      r_val_o
);
  logic [53:0] log_q[$];
  logic [1:0]  cnt_q = 2'h0;
  initial begin
    rdy_o = 1'b0;
    r_vld_o = 1'b0;
    {r_kind_o, r_ga_o, r_val_o} = 50'h0;
  end
  // slow pacing takes one cycle in four, so the sender must hold
  always @(posedge mclk_i) begin
    cnt_q <= cnt_q + 2'h1;
    rdy_o <= !slow_i || cnt_q == 2'h3;
    if (g_vld_i === 1'b1 && rdy_o) log_q.push_back({g_enc_i, g_kind_i, g_ga_i, g_val_i});
  end
  // one decoded telegram; lines show garbage once released
  task automatic send(input logic [1:0] k, input logic [15:0] ga, input logic [31:0] v);
    @(posedge mclk_i);
    r_vld_o <= 1'b1;
    {r_kind_o, r_ga_o, r_val_o} <= {k, ga, v};
    @(posedge mclk_i);
    r_vld_o <= 1'b0;
    {r_kind_o, r_ga_o, r_val_o} <= ~{k, ga, v};
  endtask : send
endmodule : kpm_bus_model

//--- sim/kpm_sync_props.sv
`timescale 1ns/1ns
// port-level checker for the sync block
module kpm_sync_props (
  // clock, reset, register port
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // bus side
  input wire logic        rx_vld_i,
  input wire logic [1:0]  rx_kind_i,
  input wire logic        tx_vld_o,
  input wire logic [1:0]  tx_kind_o,
  input wire logic [15:0] tx_ga_o,
  input wire logic [31:0] tx_val_o,
  input wire logic [3:0]  tx_enc_o,
  input wire logic        tx_rdy_i,
  input wire logic        ntf_vld_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic        rd_seen_q;
  logic [31:0] vmask;
  // a response is legal only once some bus read has been taken
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) rd_seen_q <= 1'b0;
    else if (rx_vld_i && rx_kind_i == kpm_pkg::TG_READ) rd_seen_q <= 1'b1;
  end
  // payload width allowed by the encoding code
  assign vmask = (tx_enc_o < 4'h2) ? 32'h1 : (tx_enc_o == 4'h2) ? 32'hf :
                 (tx_enc_o < 4'h6) ? 32'hff : (tx_enc_o < 4'h8) ? 32'hffff : 32'hffffffff;
  // an offered telegram waits, then must still be the same one
  sequence s_wait;
    tx_vld_o && !tx_rdy_i;
  endsequence
  sequence s_same;
    tx_vld_o && $stable(tx_kind_o) && $stable(tx_ga_o) && $stable(tx_val_o);
  endsequence
  a_tx_hold: assert property (s_wait |=> s_same)
    else $error("telegram dropped or changed before accept");
  a_ntf_cause: assert property (ntf_vld_o |-> $past(rx_vld_i) && $past(rx_kind_i) != 2'h1)
    else $error("notify without a bus write");
  a_rd_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_rst_quiet: assert property ($past(sys_rst_i) |-> !tx_vld_o && !ntf_vld_o)
    else $error("output active right after reset");
  a_kind_legal: assert property (tx_vld_o |-> tx_kind_o != 2'h3)
    else $error("illegal telegram kind");
  a_enc_legal: assert property (tx_vld_o |-> tx_enc_o <= kpm_pkg::ENC_CNT32)
    else $error("unknown encoding code");
  a_val_masked: assert property (tx_vld_o && tx_kind_o != 2'h1 |-> (tx_val_o & ~vmask) == 0)
    else $error("value wider than its encoding");
  a_resp_cause: assert property (tx_vld_o && tx_kind_o == 2'h2 |-> rd_seen_q)
    else $error("response without a bus read");
endmodule : kpm_sync_props
bind kpm_sync kpm_sync_props i_props (.*);
